// ### core/bcs_ctrl_if.sv
// bcs_ctrl_if: control bits carried from the register file to the event logic
// assumes: one clock domain
`timescale 1ns/1ps
`default_nettype none
interface bcs_ctrl_if;
   logic perr_en;
   logic serr_en;
   logic intx_dis;
   logic is_downstream;
   logic mdpe_set;
   logic sse_set;
   logic cor_fwd;
   modport regs (output perr_en, output serr_en, output intx_dis, output is_downstream,
                 input mdpe_set, input sse_set, input cor_fwd);
   modport evt (input perr_en, input serr_en, input intx_dis, input is_downstream,
                output mdpe_set, output sse_set, output cor_fwd);
endinterface
`default_nettype wire

// ### core/bcs_events.sv
// bcs_events: error forwarding, error reporting and legacy interrupt gating
// assumes: event inputs are one-cycle pulses, levels are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module bcs_events (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   bcs_ctrl_if.evt ctl,
   input wire logic rx_poison_cpl_in,
   input wire logic tx_poison_wr_in,
   input wire logic det_nonfatal_in,
   input wire logic det_fatal_in,
   input wire logic dctl_nonfatal_en_in,
   input wire logic dctl_fatal_en_in,
   input wire logic sec_err_cor_in,
   input wire logic sec_err_nonfatal_in,
   input wire logic sec_err_fatal_in,
   input wire logic own_intx_in,
   input wire logic hp_intx_in,
   input wire logic fwd_intx_in,
   output logic pri_err_cor_out,
   output logic pri_err_nonfatal_out,
   output logic pri_err_fatal_out,
   output logic pri_intx_out,
   output logic int_pending_out
);
   logic nf_report, f_report, nf_fwd, f_fwd, own_pend, own_gated;
   logic cor_r, nf_r, f_r, intx_r, pend_r;

   // poisoned traffic only flags parity error while enabled
   assign ctl.mdpe_set = ctl.perr_en & (rx_poison_cpl_in | tx_poison_wr_in);
   // own errors go out when either enable path allows
   assign nf_report = det_nonfatal_in & (ctl.serr_en | dctl_nonfatal_en_in);
   assign f_report = det_fatal_in & (ctl.serr_en | dctl_fatal_en_in);
   // secondary fatal and non-fatal messages gated, correctable always passes
   assign nf_fwd = sec_err_nonfatal_in & ctl.serr_en;
   assign f_fwd = sec_err_fatal_in & ctl.serr_en;
   assign ctl.cor_fwd = sec_err_cor_in;
   // signalled system error only for messages sent with serr enabled
   assign ctl.sse_set = ctl.serr_en & (nf_report | f_report | nf_fwd | f_fwd);
   // own pending interrupt: own and hot-plug sources on downstream ports, never upstream
   assign own_pend = ctl.is_downstream & (own_intx_in | hp_intx_in);
   assign own_gated = own_pend & ~ctl.intx_dis;

   // registered message and interrupt outputs
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cor_r <= 1'b0;
         nf_r <= 1'b0;
         f_r <= 1'b0;
         intx_r <= 1'b0;
         pend_r <= 1'b0;
      end else if (ce_in) begin
         cor_r <= ctl.cor_fwd;
         nf_r <= nf_report | nf_fwd;
         f_r <= f_report | f_fwd;
         intx_r <= own_gated | fwd_intx_in;
         pend_r <= own_pend;
      end
   end
   assign pri_err_cor_out = cor_r;
   assign pri_err_nonfatal_out = nf_r;
   assign pri_err_fatal_out = f_r;
   assign pri_intx_out = intx_r;
   assign int_pending_out = pend_r;
endmodule
`default_nettype wire

// ### core/bcs_pkg.sv
// bcs_pkg: constants for the bridge command/status register bank
// assumes: word-aligned registers on a 32-bit ahb-lite slave
package bcs_pkg;
   // register indices; each register owns one bus word at four times its index
   localparam logic [11:0] IDX_CMD = 12'h004;
   localparam logic [11:0] IDX_STS = 12'h006;
   localparam logic [11:0] ADDR_CMD = {IDX_CMD[9:0], 2'b00};
   localparam logic [11:0] ADDR_STS = {IDX_STS[9:0], 2'b00};
   // byte addresses of the event registers and the port setup word
   localparam logic [11:0] ADDR_INT_STS = 12'h040;
   localparam logic [11:0] ADDR_INT_MASK = 12'h044;
   localparam logic [11:0] ADDR_PORT_CFG = 12'h048;
   // command field positions
   localparam int CMD_PERR_EN_BIT = 6;
   localparam int CMD_SERR_EN_BIT = 8;
   localparam int CMD_INTX_DIS_BIT = 10;
   // status field positions (status word sits at bits 15:0 of its own bus word)
   localparam int STS_INT_PEND_BIT = 3;
   localparam int STS_CAP_LIST_BIT = 4;
   localparam int STS_MDPE_BIT = 8;
   localparam int STS_SSE_BIT = 14;
   localparam logic CAP_LIST_VALUE = 1'b1;
   localparam logic CTRL_RESET = 1'b0;
   // event status bits in the interrupt status/mask registers
   localparam int EV_MDPE_BIT = 0;
   localparam int EV_SSE_BIT = 1;
   localparam int EV_COR_BIT = 2;
   localparam int EV_INTX_BIT = 3;
   localparam int EV_COUNT = 4;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
   // ahb constants
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage

// ### core/bcs_top.sv
// bcs_top: bridge command/status bits behind an ahb-lite slave
// assumes: single 10 mhz clock, synchronous active-low reset, one bus master
`timescale 1ns/1ps
`default_nettype none
module bcs_top (
   input wire logic CORE_CLK_IN,
   input wire logic RSTN_IN,
   input wire logic CE_IN,
   input wire logic HSEL_IN,
   input wire logic [11:0] HADDR_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [2:0] HSIZE_IN,
   input wire logic [31:0] HWDATA_IN,
   input wire logic HREADY_IN,
   output logic [31:0] HRDATA_OUT,
   output logic HREADYOUT_OUT,
   output logic HRESP_OUT,
   input wire logic RX_POISON_CPL_IN,
   input wire logic TX_POISON_WR_IN,
   input wire logic DET_NONFATAL_IN,
   input wire logic DET_FATAL_IN,
   input wire logic DCTL_NONFATAL_EN_IN,
   input wire logic DCTL_FATAL_EN_IN,
   input wire logic SEC_ERR_COR_IN,
   input wire logic SEC_ERR_NONFATAL_IN,
   input wire logic SEC_ERR_FATAL_IN,
   input wire logic OWN_INTX_IN,
   input wire logic HP_INTX_IN,
   input wire logic FWD_INTX_IN,
   output logic PRI_ERR_COR_OUT,
   output logic PRI_ERR_NONFATAL_OUT,
   output logic PRI_ERR_FATAL_OUT,
   output logic PRI_INTX_OUT,
   output logic IRQ_OUT
);
   bcs_ctrl_if ctl ();

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic perr_en_r, serr_en_r, intx_dis_r, downstream_r;
   logic mdpe_r, sse_r;
   logic [bcs_pkg::EV_COUNT-1:0] ev_sts_r, ev_mask_r, ev_in;
   logic [31:0] rdata_r;
   logic wr_pend_r;
   logic [11:0] wr_addr_r;
   logic int_pend;

   ////////////////////////////////////////////////////////////////////////////
   // ahb address phase decode
   wire addr_ok = HSEL_IN & HREADY_IN & HTRANS_IN[1];
   wire rd_req = addr_ok & ~HWRITE_IN;
   wire wr_req = addr_ok & HWRITE_IN;
   wire wr_cmd = wr_pend_r & (wr_addr_r == bcs_pkg::ADDR_CMD);
   wire wr_sts = wr_pend_r & (wr_addr_r == bcs_pkg::ADDR_STS);
   wire wr_ists = wr_pend_r & (wr_addr_r == bcs_pkg::ADDR_INT_STS);
   wire wr_mask = wr_pend_r & (wr_addr_r == bcs_pkg::ADDR_INT_MASK);
   wire wr_port = wr_pend_r & (wr_addr_r == bcs_pkg::ADDR_PORT_CFG);
   // status word carries the write-one-to-clear bits
   wire clr_mdpe = wr_sts & HWDATA_IN[bcs_pkg::STS_MDPE_BIT];
   wire clr_sse = wr_sts & HWDATA_IN[bcs_pkg::STS_SSE_BIT];

   // command and status words; unlisted bits are constant zero
   logic [15:0] cmd_word, sts_word;
   always_comb begin
      cmd_word = 16'h0000;
      cmd_word[bcs_pkg::CMD_PERR_EN_BIT] = perr_en_r;
      cmd_word[bcs_pkg::CMD_SERR_EN_BIT] = serr_en_r;
      cmd_word[bcs_pkg::CMD_INTX_DIS_BIT] = intx_dis_r;
      sts_word = 16'h0000;
      sts_word[bcs_pkg::STS_INT_PEND_BIT] = int_pend;
      sts_word[bcs_pkg::STS_CAP_LIST_BIT] = bcs_pkg::CAP_LIST_VALUE;
      sts_word[bcs_pkg::STS_MDPE_BIT] = mdpe_r;
      sts_word[bcs_pkg::STS_SSE_BIT] = sse_r;
   end

   // read mux, unmapped addresses read zero
   wire [31:0] rd_mux =
      (HADDR_IN == bcs_pkg::ADDR_CMD) ? {16'h0000, cmd_word} :
      (HADDR_IN == bcs_pkg::ADDR_STS) ? {16'h0000, sts_word} :
      (HADDR_IN == bcs_pkg::ADDR_INT_STS) ? {{(32-bcs_pkg::EV_COUNT){1'b0}}, ev_sts_r} :
      (HADDR_IN == bcs_pkg::ADDR_INT_MASK) ? {{(32-bcs_pkg::EV_COUNT){1'b0}}, ev_mask_r} :
      (HADDR_IN == bcs_pkg::ADDR_PORT_CFG) ? {31'h0000_0000, downstream_r} :
      bcs_pkg::RDATA_RESET;

   ////////////////////////////////////////////////////////////////////////////
   // bus pipeline: zero wait states
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RSTN_IN) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 12'h000;
         rdata_r <= bcs_pkg::RDATA_RESET;
      end else if (CE_IN) begin
         wr_pend_r <= wr_req;
         wr_addr_r <= HADDR_IN;
         if (rd_req) begin
            rdata_r <= rd_mux;
         end
      end
   end
   assign HRDATA_OUT = rdata_r;
   assign HREADYOUT_OUT = 1'b1;
   assign HRESP_OUT = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // command controls, read-write, reset to zero
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RSTN_IN) begin
         perr_en_r <= bcs_pkg::CTRL_RESET;
         serr_en_r <= bcs_pkg::CTRL_RESET;
         intx_dis_r <= bcs_pkg::CTRL_RESET;
         downstream_r <= 1'b0;
      end else if (CE_IN) begin
         if (wr_cmd) begin
            perr_en_r <= HWDATA_IN[bcs_pkg::CMD_PERR_EN_BIT];
            serr_en_r <= HWDATA_IN[bcs_pkg::CMD_SERR_EN_BIT];
            intx_dis_r <= HWDATA_IN[bcs_pkg::CMD_INTX_DIS_BIT];
         end
         if (wr_port) begin
            downstream_r <= HWDATA_IN[0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status flags: set wins over write-one clear
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RSTN_IN) begin
         mdpe_r <= 1'b0;
         sse_r <= 1'b0;
      end else if (CE_IN) begin
         mdpe_r <= ctl.mdpe_set | (mdpe_r & ~clr_mdpe);
         sse_r <= ctl.sse_set | (sse_r & ~clr_sse);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status and mask
   assign ev_in[bcs_pkg::EV_MDPE_BIT] = ctl.mdpe_set;
   assign ev_in[bcs_pkg::EV_SSE_BIT] = ctl.sse_set;
   assign ev_in[bcs_pkg::EV_COR_BIT] = ctl.cor_fwd;
   assign ev_in[bcs_pkg::EV_INTX_BIT] = int_pend;
   genvar gi;
   generate
      for (gi = 0; gi < bcs_pkg::EV_COUNT; gi = gi + 1) begin : g_ev
         always_ff @(posedge CORE_CLK_IN) begin
            if (!RSTN_IN) begin
               ev_sts_r[gi] <= 1'b0;
               ev_mask_r[gi] <= 1'b0;
            end else if (CE_IN) begin
               ev_sts_r[gi] <= ev_in[gi] | (ev_sts_r[gi] & ~(wr_ists & HWDATA_IN[gi]));
               if (wr_mask) begin
                  ev_mask_r[gi] <= HWDATA_IN[gi];
               end
            end
         end
      end
   endgenerate
   assign IRQ_OUT = |(ev_sts_r & ev_mask_r);

   ////////////////////////////////////////////////////////////////////////////
   // control bits to the event logic
   assign ctl.perr_en = perr_en_r;
   assign ctl.serr_en = serr_en_r;
   assign ctl.intx_dis = intx_dis_r;
   assign ctl.is_downstream = downstream_r;

   bcs_events u_events (
      .clk_in(CORE_CLK_IN),
      .rst_n_in(RSTN_IN),
      .ce_in(CE_IN),
      .ctl(ctl.evt),
      .rx_poison_cpl_in(RX_POISON_CPL_IN),
      .tx_poison_wr_in(TX_POISON_WR_IN),
      .det_nonfatal_in(DET_NONFATAL_IN),
      .det_fatal_in(DET_FATAL_IN),
      .dctl_nonfatal_en_in(DCTL_NONFATAL_EN_IN),
      .dctl_fatal_en_in(DCTL_FATAL_EN_IN),
      .sec_err_cor_in(SEC_ERR_COR_IN),
      .sec_err_nonfatal_in(SEC_ERR_NONFATAL_IN),
      .sec_err_fatal_in(SEC_ERR_FATAL_IN),
      .own_intx_in(OWN_INTX_IN),
      .hp_intx_in(HP_INTX_IN),
      .fwd_intx_in(FWD_INTX_IN),
      .pri_err_cor_out(PRI_ERR_COR_OUT),
      .pri_err_nonfatal_out(PRI_ERR_NONFATAL_OUT),
      .pri_err_fatal_out(PRI_ERR_FATAL_OUT),
      .pri_intx_out(PRI_INTX_OUT),
      .int_pending_out(int_pend)
   );
endmodule
`default_nettype wire

// ### dv/bcs_asserts.sv
// bcs_chk: port-level checks of the bridge command/status block
// assumes: bound into bcs_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module bcs_chk (
   input wire logic CORE_CLK_IN,
   input wire logic RSTN_IN,
   input wire logic CE_IN,
   input wire logic HSEL_IN,
   input wire logic [1:0] HTRANS_IN,
   input wire logic HWRITE_IN,
   input wire logic [31:0] HRDATA_OUT,
   input wire logic HREADYOUT_OUT,
   input wire logic HRESP_OUT,
   input wire logic DET_NONFATAL_IN,
   input wire logic DET_FATAL_IN,
   input wire logic DCTL_NONFATAL_EN_IN,
   input wire logic DCTL_FATAL_EN_IN,
   input wire logic SEC_ERR_COR_IN,
   input wire logic SEC_ERR_NONFATAL_IN,
   input wire logic SEC_ERR_FATAL_IN,
   input wire logic OWN_INTX_IN,
   input wire logic HP_INTX_IN,
   input wire logic FWD_INTX_IN,
   input wire logic PRI_ERR_COR_OUT,
   input wire logic PRI_ERR_NONFATAL_OUT,
   input wire logic PRI_ERR_FATAL_OUT,
   input wire logic PRI_INTX_OUT
);
   // frozen cycles are skipped, state does not move then
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RSTN_IN || !CE_IN);
   a_bus_okay: assert property (HREADYOUT_OUT && !HRESP_OUT)
      else $error("bus not ready or not okay");
   a_rdata_hold: assert property ($changed(HRDATA_OUT)
      |-> $past(HSEL_IN && HTRANS_IN[1] && !HWRITE_IN)) else $error("read data moved without read");
   a_cor_fwd: assert property (SEC_ERR_COR_IN |=> PRI_ERR_COR_OUT)
      else $error("correctable message dropped");
   a_nonfat_cause: assert property (PRI_ERR_NONFATAL_OUT
      |-> $past(SEC_ERR_NONFATAL_IN || DET_NONFATAL_IN)) else $error("non-fatal out without cause");
   a_fatal_cause: assert property (PRI_ERR_FATAL_OUT
      |-> $past(SEC_ERR_FATAL_IN || DET_FATAL_IN)) else $error("fatal out without cause");
   a_det_fatal: assert property (DET_FATAL_IN && DCTL_FATAL_EN_IN |=> PRI_ERR_FATAL_OUT)
      else $error("enabled fatal not reported");
   a_det_nonfat: assert property (DET_NONFATAL_IN && DCTL_NONFATAL_EN_IN |=> PRI_ERR_NONFATAL_OUT)
      else $error("enabled non-fatal not reported");
   a_fwd_intx: assert property (FWD_INTX_IN |=> PRI_INTX_OUT)
      else $error("forwarded interrupt lost");
   a_intx_idle: assert property (!OWN_INTX_IN && !HP_INTX_IN && !FWD_INTX_IN |=> !PRI_INTX_OUT)
      else $error("interrupt without source");
endmodule
bind bcs_top bcs_chk chk_u (.CORE_CLK_IN, .RSTN_IN, .CE_IN, .HSEL_IN, .HTRANS_IN, .HWRITE_IN, .HRDATA_OUT,
   .HREADYOUT_OUT, .HRESP_OUT, .DET_NONFATAL_IN, .DET_FATAL_IN, .DCTL_NONFATAL_EN_IN, .DCTL_FATAL_EN_IN,
   .SEC_ERR_COR_IN, .SEC_ERR_NONFATAL_IN, .SEC_ERR_FATAL_IN, .OWN_INTX_IN, .HP_INTX_IN, .FWD_INTX_IN,
   .PRI_ERR_COR_OUT, .PRI_ERR_NONFATAL_OUT, .PRI_ERR_FATAL_OUT, .PRI_INTX_OUT);
`default_nettype wire

// ### dv/bcs_host_model.sv
// bcs_host_model: configuration software as a single-transfer ahb-lite master
// assumes: one slave; each transfer starts right after a rising edge
`timescale 1ns/1ps
`default_nettype none
module bcs_host_model (
   input wire logic clk_in,
   input wire logic ready_in,
   input wire logic [31:0] rdata_in,
   output logic sel_out,
   output logic [11:0] addr_out,
   output logic [1:0] trans_out,
   output logic write_out,
   output logic [31:0] wdata_out,
   output logic hung_out
);
   initial begin
      sel_out = 1'b0;
      addr_out = 12'h000;
      trans_out = 2'h0;
      write_out = 1'b0;
      wdata_out = 32'h0000_0000;
      hung_out = 1'b0;
   end
   // bounded wait for hready sampled high
   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge clk_in);
      while (ready_in !== 1'b1 && n < 64) begin
         @(posedge clk_in);
         n++;
      end
      if (n == 64) hung_out <= 1'b1;
   endtask
   // address phase, then data phase; read data taken at its end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_in);
      sel_out <= 1'b1;
      addr_out <= a;
      trans_out <= bcs_pkg::HTRANS_NONSEQ;
      write_out <= w;
      wait_rdy();
      sel_out <= 1'b0;
      trans_out <= 2'h0;
      wdata_out <= w ? d : ~wdata_out;
      wait_rdy();
      q = rdata_in;
   endtask
endmodule
`default_nettype wire

// ### dv/bcs_tb.sv
// tb: self-checking bench for bcs_top
// assumes: host model drives the bus, bench drives events and levels
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic [6:0] ev = 7'h00;
   logic [4:0] lv = 5'h00;
   logic [31:0] q;
   wire logic sel, wrt, rdy, resp, cor, nf, fat, intx, irq, hung;
   wire logic [11:0] addr;
   wire logic [1:0] trans;
   wire logic [31:0] wdata, rdata;
   int bad_count = 0;
   int num_checks = 0;
   localparam logic [11:0] CM = bcs_pkg::ADDR_CMD;
   localparam logic [11:0] ST = bcs_pkg::ADDR_STS;
   initial forever #50 clk = ~clk;
   bcs_host_model host_u (.clk_in(clk), .ready_in(rdy), .rdata_in(rdata), .sel_out(sel), .addr_out(addr),
      .trans_out(trans), .write_out(wrt), .wdata_out(wdata), .hung_out(hung));
   bcs_top dut_u (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .HSEL_IN(sel), .HADDR_IN(addr),
      .HTRANS_IN(trans), .HWRITE_IN(wrt), .HSIZE_IN(3'h2), .HWDATA_IN(wdata), .HREADY_IN(rdy),
      .HRDATA_OUT(rdata), .HREADYOUT_OUT(rdy), .HRESP_OUT(resp), .RX_POISON_CPL_IN(ev[0]),
      .TX_POISON_WR_IN(ev[1]), .DET_NONFATAL_IN(ev[2]), .DET_FATAL_IN(ev[3]), .DCTL_NONFATAL_EN_IN(lv[0]),
      .DCTL_FATAL_EN_IN(lv[1]), .SEC_ERR_COR_IN(ev[4]), .SEC_ERR_NONFATAL_IN(ev[5]), .SEC_ERR_FATAL_IN(ev[6]),
      .OWN_INTX_IN(lv[2]), .HP_INTX_IN(lv[3]), .FWD_INTX_IN(lv[4]), .PRI_ERR_COR_OUT(cor),
      .PRI_ERR_NONFATAL_OUT(nf), .PRI_ERR_FATAL_OUT(fat), .PRI_INTX_OUT(intx), .IRQ_OUT(irq));
   ////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      host_u.xfer(1'b1, a, d, q);
      #1;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] exp);
      host_u.xfer(1'b0, a, 32'h0, q);
      chk(q, exp);
      #1;
   endtask
   // one-cycle event pulse, returns once its answer has landed
   task pulse(input int b);
      @(posedge clk);
      ev[b] <= 1'b1;
      @(posedge clk);
      ev <= 7'h00;
      #1;
   endtask
   task lvl(input logic [4:0] v);
      @(posedge clk);
      lv <= v;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task conclude;
      if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task t_reset;
      rd(CM, 32'h0);
      rd(ST, 32'h10);
      rd(bcs_pkg::ADDR_INT_STS, 32'h0);
      rd(bcs_pkg::ADDR_PORT_CFG, 32'h0);
      rd(12'h0fc, 32'h0);
      wr(CM, 32'hffff_ffff);
      wr(ST, 32'hffff_ffff);
      rd(CM, 32'h540);
      rd(ST, 32'h10);
      wr(CM, 32'h0);
      rd(CM, 32'h0);
   endtask
   task t_parity;
      pulse(0);
      rd(ST, 32'h10);
      wr(CM, 32'h40);
      pulse(1);
      rd(ST, 32'h110);
      wr(ST, 32'h100);
      rd(ST, 32'h10);
      rd(CM, 32'h40);
      pulse(0);
      rd(ST, 32'h110);
      wr(ST, 32'h100);
      wr(CM, 32'h0);
   endtask
   task t_errors;
      lvl(5'h03);
      pulse(5);
      chk(nf, 1'b0);
      pulse(4);
      chk(cor, 1'b1);
      pulse(3);
      chk(fat, 1'b1);
      pulse(2);
      chk(nf, 1'b1);
      rd(ST, 32'h10);
      wr(CM, 32'h100);
      pulse(6);
      chk(fat, 1'b1);
      rd(ST, 32'h4010);
      wr(ST, 32'h4000);
      wr(CM, 32'h0);
   endtask
   task t_intx;
      lvl(5'h0c);
      rd(ST, 32'h10);
      wr(bcs_pkg::ADDR_PORT_CFG, 32'h1);
      lvl(5'h08);
      rd(ST, 32'h18);
      wr(CM, 32'h400);
      lvl(5'h10);
      chk(intx, 1'b1);
      rd(ST, 32'h10);
      lvl(5'h04);
      chk(intx, 1'b0);
      rd(ST, 32'h18);
      wr(CM, 32'h0);
      lvl(5'h04);
      chk(intx, 1'b1);
      lvl(5'h00);
      wr(bcs_pkg::ADDR_PORT_CFG, 32'h0);
   endtask
   // sticky event, masked, unmasked, then cleared by a written one
   task t_irq;
      wr(bcs_pkg::ADDR_INT_STS, 32'hf);
      rd(bcs_pkg::ADDR_INT_STS, 32'h0);
      pulse(4);
      rd(bcs_pkg::ADDR_INT_STS, 32'h4);
      chk(irq, 1'b0);
      wr(bcs_pkg::ADDR_INT_MASK, 32'h4);
      chk(irq, 1'b1);
      wr(bcs_pkg::ADDR_INT_STS, 32'h4);
      chk(irq, 1'b0);
      rd(bcs_pkg::ADDR_INT_MASK, 32'h4);
   endtask
   // clock enable low: events, messages and bus writes are all frozen
   task t_freeze;
      @(posedge clk);
      ce <= 1'b0;
      pulse(4);
      chk(cor, 1'b0);
      wr(bcs_pkg::ADDR_INT_MASK, 32'hf);
      @(posedge clk);
      ce <= 1'b1;
      rd(bcs_pkg::ADDR_INT_MASK, 32'h4);
      rd(bcs_pkg::ADDR_INT_STS, 32'h0);
      chk(irq, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_parity();
      t_errors();
      t_intx();
      t_irq();
      t_freeze();
      conclude();
   end
   // bus hang or overall run limit ends the run as a mismatch
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      conclude();
   end
   always @(posedge hung) begin
      bad_count++;
      conclude();
   end
endmodule
`default_nettype wire
